// >>> inc/wrap_positioning_pkg.sv
// constants, types and field layouts of the wrap positioning sequencer
// assumes one 40 MHz control clock; profiles are written through a plain load port
//
// What this block does
// [RULE_01] wrap absolute: target folded into wrap range, moves inside range
// [RULE_02] wrap proximity: rotate the shorter way to the folded target
// [RULE_03] wrap forward: always rotate forward to the folded target
// [RULE_04] wrap reverse: always rotate in reverse to the folded target
// [RULE_05] wrap range held as whole motor revolutions, e.g. 18
// [RULE_06] wrap offset ratio in percent places home inside the span
// [RULE_07] host sets wrap coordinates manual, range, offset, wrap enable
// [RULE_08] host asserts servo-on before commanding a move
// [RULE_09] host checks ready is high before requesting a move
// [RULE_10] host presents profile number then raises start
// [RULE_11] on accepted start, ready drops and the motor is driven
// [RULE_12] host releases start after seeing ready drop
// [RULE_13] ready returns high when the move finishes
// [RULE_14] eight select bits decode as binary, bit 0 lsb, 0 to 255
// [RULE_15] negative profile speed runs at its magnitude
// [RULE_16] command position folds at the range ends in the travel direction
package wrap_positioning_pkg;

  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;

  localparam int unsigned POS_W     = 32;
  localparam int unsigned SPEED_W   = 24;
  localparam int unsigned SEL_W     = 8;
  localparam int unsigned PROF_N    = 256;
  localparam int unsigned REV_W     = 16;
  localparam int unsigned PCT_W     = 7;
  localparam int unsigned ACC_W     = 32;

  localparam logic [31:0] STEPS_PER_REV = 32'h0000_03E8;
  localparam logic [63:0] PCT_FULL      = 64'h0000_0000_0000_0064;
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_HZ);

  // synchronised pin vector layout
  localparam int unsigned PIN_W     = SEL_W + 2;
  localparam int unsigned PIN_START = SEL_W;
  localparam int unsigned PIN_SERVO = SEL_W + 1;

  typedef enum logic [1:0] {
    WRAP_ABSOLUTE,
    WRAP_PROXIMITY,
    WRAP_FORWARD,
    WRAP_REVERSE
  } wrap_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PLAN,
    ST_RUN
  } run_state_t;

  typedef struct packed {
    wrap_mode_t                mode;
    logic signed [POS_W-1:0]   target;
    logic signed [SPEED_W-1:0] speed;
  } profile_t;

endpackage : wrap_positioning_pkg

// >>> rtl/wrap_positioning_sequencer.sv
// stored profile run sequencer for wrapped coordinate positioning
// assumes discrete pins from the host are asynchronous to clk; profile load port is on clk
`timescale 1ns/1ps

module wrap_positioning_sequencer
  import wrap_positioning_pkg::*;
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // host discrete inputs
  input  wire logic                     servoOn,
  input  wire logic [SEL_W-1:0]         profileSelectBits,
  input  wire logic                     startIn,
  // wrap configuration
  input  wire logic                     wrapEnable,
  input  wire logic [REV_W-1:0]         wrapRangeRev,
  input  wire logic [PCT_W-1:0]         wrapOffsetPct,
  // profile load
  input  wire logic                     profWe,
  input  wire logic [SEL_W-1:0]         profAddr,
  input  wire logic [1:0]               profMode,
  input  wire logic signed [POS_W-1:0]  profTarget,
  input  wire logic signed [SPEED_W-1:0] profSpeed,
  // motion and status outputs
  output logic                          ready,
  output logic                          busy,
  output logic                          stepPulse,
  output logic                          forwardRotation,
  output logic signed [POS_W-1:0]       cmdPos
);

  typedef struct packed {
    logic [PIN_W-1:0]          sync1;
    logic [PIN_W-1:0]          sync2;
    logic [PIN_W-1:0]          sync3;
    logic [PIN_W-1:0]          pinLvl;
    logic                      startPrev;
    run_state_t                state;
    logic                      ready;
    logic                      stepPulse;
    logic                      forward_rotation;
    profile_t                  cur;
    logic signed [POS_W-1:0]   pos;
    logic [POS_W-1:0]          remain;
    logic [ACC_W-1:0]          acc;
    profile_t [PROF_N-1:0]     prof;
  } seq_state_t;

  seq_state_t q_r;
  seq_state_t q_nxt;

  logic signed [63:0] span;
  logic signed [63:0] lowBound;
  logic signed [63:0] highBound;

  // fold any coordinate into [low, low+span)
  function automatic logic signed [63:0] foldPos(input logic signed [63:0] p,
                                                 input logic signed [63:0] low,
                                                 input logic signed [63:0] sp);
    logic signed [63:0] m;
    m = (p - low) % sp;
    if (m < 0) begin
      m = m + sp;
    end
    return low + m;
  endfunction : foldPos

  function automatic logic [ACC_W-1:0] speedMag(input logic signed [SPEED_W-1:0] s);
    logic [SPEED_W-1:0] m;
    m = (s < 0) ? SPEED_W'(-s) : SPEED_W'(s);
    if (m == '0) begin
      m = SPEED_W'(1);
    end
    return ACC_W'(m);
  endfunction : speedMag

  // span and bounds of the wrapped coordinate system
  always_comb begin
    span      = $signed({32'h0000_0000, 16'h0000, wrapRangeRev}) * $signed({32'h0000_0000, STEPS_PER_REV}); // RULE_05
    if (span < 64'sd1) begin
      span = 64'sd1;
    end
    lowBound  = -((span * $signed({57'h0, wrapOffsetPct})) / $signed(PCT_FULL)); // RULE_06
    highBound = lowBound + span - 64'sd1;
  end

  always_comb begin
    logic               startRise;
    logic               servoLvl;
    logic [SEL_W-1:0]   selNum;
    logic signed [63:0] tgt;
    logic signed [63:0] here;
    logic signed [63:0] fwdDist;
    logic signed [63:0] revDist;
    logic [ACC_W-1:0]   accSum;
    q_nxt      = q_r;
    startRise  = 1'b0;
    servoLvl   = 1'b0;
    selNum     = '0;
    tgt        = '0;
    here       = '0;
    fwdDist    = '0;
    revDist    = '0;
    accSum     = '0;

    // pin synchroniser, change taken once stages two and three agree
    q_nxt.sync1 = {servoOn, startIn, profileSelectBits};
    q_nxt.sync2 = q_r.sync1;
    q_nxt.sync3 = q_r.sync2;
    if (q_r.sync2 == q_r.sync3) begin
      q_nxt.pinLvl = q_r.sync3;
    end
    q_nxt.startPrev = q_r.pinLvl[PIN_START];
    startRise = q_r.pinLvl[PIN_START] & ~q_r.startPrev;
    servoLvl  = q_r.pinLvl[PIN_SERVO];
    selNum    = q_r.pinLvl[SEL_W-1:0]; // RULE_14

    q_nxt.stepPulse = 1'b0;

    if (profWe) begin
      q_nxt.prof[profAddr] = '{mode: wrap_mode_t'(profMode), target: profTarget,
                               speed: profSpeed};
    end

    case (q_r.state)
      ST_IDLE: begin
        q_nxt.ready = servoLvl & wrapEnable; // RULE_13
        if (startRise && q_r.ready && servoLvl && wrapEnable) begin
          q_nxt.ready = 1'b0; // RULE_11
          q_nxt.cur   = q_r.prof[selNum]; // RULE_14
          q_nxt.acc   = '0;
          q_nxt.state = ST_PLAN;
        end
      end
      ST_PLAN: begin
        here    = foldPos(64'(q_r.pos), lowBound, span);
        tgt     = foldPos(64'(q_r.cur.target), lowBound, span); // RULE_01
        fwdDist = foldPos(tgt - here, 64'sd0, span);
        revDist = (fwdDist == 64'sd0) ? 64'sd0 : span - fwdDist;
        q_nxt.pos = POS_W'(here);
        case (q_r.cur.mode)
          WRAP_ABSOLUTE: begin
            q_nxt.forward_rotation    = (tgt >= here); // RULE_01
            q_nxt.remain = (tgt >= here) ? POS_W'(tgt - here) : POS_W'(here - tgt);
          end
          WRAP_PROXIMITY: begin
            q_nxt.forward_rotation    = (fwdDist <= revDist); // RULE_02
            q_nxt.remain = (fwdDist <= revDist) ? POS_W'(fwdDist) : POS_W'(revDist);
          end
          WRAP_FORWARD: begin
            q_nxt.forward_rotation    = 1'b1; // RULE_03
            q_nxt.remain = POS_W'(fwdDist);
          end
          WRAP_REVERSE: begin
            q_nxt.forward_rotation    = 1'b0; // RULE_04
            q_nxt.remain = POS_W'(revDist);
          end
          default: begin
            q_nxt.forward_rotation    = 1'b1;
            q_nxt.remain = '0;
          end
        endcase
        q_nxt.state = ST_RUN;
      end
      ST_RUN: begin
        if (!servoLvl || !wrapEnable) begin
          // servo or wrap enable dropped: abandon the move
          q_nxt.state = ST_IDLE;
        end else if (q_r.remain == '0) begin
          q_nxt.state = ST_IDLE; // RULE_13
        end else begin
          accSum = q_r.acc + speedMag(q_r.cur.speed); // RULE_15
          if (accSum >= ACC_WRAP) begin
            q_nxt.acc       = accSum - ACC_WRAP;
            q_nxt.stepPulse = 1'b1; // RULE_11
            q_nxt.remain    = q_r.remain - POS_W'(1);
            if (q_r.forward_rotation) begin
              q_nxt.pos = (64'(q_r.pos) >= highBound) ? POS_W'(lowBound)
                                                       : q_r.pos + POS_W'(1); // RULE_16
            end else begin
              q_nxt.pos = (64'(q_r.pos) <= lowBound) ? POS_W'(highBound)
                                                      : q_r.pos - POS_W'(1); // RULE_16
            end
          end else begin
            q_nxt.acc = accSum;
          end
        end
      end
      default: begin
        q_nxt.state = ST_IDLE;
        q_nxt.ready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign ready           = q_r.ready;
  assign busy            = (q_r.state != ST_IDLE);
  assign stepPulse       = q_r.stepPulse;
  assign forwardRotation = q_r.forward_rotation;
  assign cmdPos          = q_r.pos;

endmodule : wrap_positioning_sequencer

// >>> testbench/wrap_positioning_sequencer_asserts.sv
// checker: handshake, stepping and folding at the sequencer ports
// assumes one clock domain and a bind to the sequencer
`timescale 1ns/1ps
module wrap_positioning_sequencer_asserts
  import wrap_positioning_pkg::*;
(
  // clock and reset
  input wire logic                    clk,
  input wire logic                    rst_b,
  // inputs watched
  input wire logic                    servoOn,
  input wire logic                    startIn,
  input wire logic                    wrapEnable,
  input wire logic [REV_W-1:0]        wrapRangeRev,
  input wire logic [PCT_W-1:0]        wrapOffsetPct,
  // outputs watched
  input wire logic                    ready,
  input wire logic                    busy,
  input wire logic                    stepPulse,
  input wire logic                    forwardRotation,
  input wire logic signed [POS_W-1:0] cmdPos
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  longint lo;
  longint hi;
  assign lo = -((longint'(wrapRangeRev) * 1000 * longint'(wrapOffsetPct)) / 100);
  assign hi = lo + longint'(wrapRangeRev) * 1000 - 1;
  a_busy_blocks_ready: assert property (busy |-> !ready)
    else $error("ready high while busy");
  a_start_drops_ready: assert property ($rose(startIn) && ready && servoOn && wrapEnable
    |-> ##[2:7] !ready)
    else $error("start did not drop ready");
  a_ready_comes_back: assert property ($fell(busy) && servoOn && wrapEnable |-> ##[1:2] ready)
    else $error("ready not back after move");
  a_step_needs_run: assert property (stepPulse |-> $past(busy))
    else $error("step outside a move");
  a_step_in_range: assert property (stepPulse |-> cmdPos >= lo && cmdPos <= hi)
    else $error("position outside wrap range");
  a_fwd_step_fold: assert property (stepPulse && forwardRotation |->
    cmdPos == $past(cmdPos) + 1 || (cmdPos == lo && $past(cmdPos) == hi))
    else $error("bad forward step");
  a_dir_holds_run: assert property (busy && $past(busy, 2) |-> $stable(forwardRotation))
    else $error("direction changed mid move");
  a_wrap_off_idle: assert property (!wrapEnable |-> ##[0:2] !ready)
    else $error("ready while wrap disabled");
endmodule : wrap_positioning_sequencer_asserts

bind wrap_positioning_sequencer wrap_positioning_sequencer_asserts uChk (
  .clk, .rst_b, .servoOn, .startIn, .wrapEnable, .wrapRangeRev, .wrapOffsetPct,
  .ready, .busy, .stepPulse, .forwardRotation, .cmdPos
);

// >>> testbench/host_io_model.sv
// host side: profile select and start handshake
// assumes ready is sampled at the falling edge, pins change at the rising edge
`timescale 1ns/1ps
module host_io_model
  import wrap_positioning_pkg::*;
(
  // host pins
  input  wire logic        clk,
  input  wire logic        ready,
  output logic [SEL_W-1:0] profileSelectBits,
  output logic             startIn
);
  initial begin
    profileSelectBits = 8'h00;
    startIn = 1'b0;
  end
  task automatic wait_ready(input logic lvl, output bit ok);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ready !== lvl && n < 6000);
    ok = (ready === lvl);
  endtask : wait_ready
  task automatic move(input logic [SEL_W-1:0] num, output bit ok);
    bit a;
    bit b;
    bit c;
    wait_ready(1'b1, a);
    @(posedge clk) profileSelectBits <= num;
    @(posedge clk) startIn <= 1'b1;
    wait_ready(1'b0, b);
    @(posedge clk) startIn <= 1'b0;
    profileSelectBits <= ~num;
    wait_ready(1'b1, c);
    ok = a & b & c;
  endtask : move
endmodule : host_io_model

// >>> testbench/tb_top.sv
// bench: moves in every wrap mode, judged on position, direction and step count
// assumes the checker binds itself; span 1000 steps, offset 50 percent
`timescale 1ns/1ps
module tb_top
  import wrap_positioning_pkg::*;
;
  logic                      clk = 1'b0;
  logic                      rst_b = 1'b0;
  logic                      servoOn = 1'b0;
  logic                      wrapEnable = 1'b0;
  logic                      profWe = 1'b0;
  logic [SEL_W-1:0]          profAddr = 8'h00;
  logic [1:0]                profMode = 2'h0;
  logic signed [POS_W-1:0]   profTarget = 32'h0;
  logic signed [SPEED_W-1:0] profSpeed = 24'h0;
  logic [SEL_W-1:0]          profileSelectBits;
  logic                      startIn, ready, busy, stepPulse, forwardRotation;
  logic signed [POS_W-1:0]   cmdPos;
  int                        failures = 0;
  int                        num_checks = 0;
  int                        steps = 0;
  bit                        ok;
  // target, end position, steps
  localparam logic [31:0] TAB [5][3] = '{'{32'h0000_00FA, 32'h0000_00FA, 32'h0000_00FA},
    '{32'hFFFF_FE70, 32'hFFFF_FE70, 32'h0000_015E}, '{32'h0000_012C, 32'h0000_012C, 32'h0000_02BC},
    '{32'h0000_0190, 32'h0000_0190, 32'h0000_0384}, '{32'h0000_0384, 32'hFFFF_FF9C, 32'h0000_01F4}};
  wrap_positioning_sequencer uut (.clk, .rst_b, .servoOn, .profileSelectBits, .startIn,
    .wrapEnable, .wrapRangeRev(16'h0001), .wrapOffsetPct(7'h32), .profWe, .profAddr,
    .profMode, .profTarget, .profSpeed, .ready, .busy, .stepPulse, .forwardRotation, .cmdPos);
  host_io_model uHost (.clk, .ready, .profileSelectBits, .startIn);
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) if (stepPulse === 1'b1) steps <= steps + 1;
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic test_reset();
    repeat (20) @(posedge clk);
    chk("cmdPos", 32'h0, cmdPos);
    rst_b <= 1'b1;
    servoOn <= 1'b1;
    repeat (8) @(negedge clk);
    chk("ready", 32'h0, 32'(ready));
    @(posedge clk) wrapEnable <= 1'b1;
    $display("test reset done");
  endtask : test_reset
  task automatic test_modes();
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) profWe <= 1'b1;
      profAddr <= 8'(i * 85);
      profMode <= 2'(i);
      profTarget <= TAB[i][0];
      profSpeed <= 24'h85_EE00;
    end
    @(posedge clk) profWe <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      steps = 0;
      uHost.move(8'(i * 85), ok);
      chk("ok", 32'h1, ok);
      chk("pos", TAB[i][1], cmdPos);
      chk("dir", 32'(i < 3), 32'(forwardRotation));
      chk("steps", TAB[i][2], 32'(steps));
    end
    $display("test modes done");
  endtask : test_modes
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    print_verdict();
  end
  initial begin
    test_reset();
    test_modes();
    print_verdict();
  end
endmodule : tb_top
